// [include/dmc_pkg.sv]
package dmc_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned SYS_CLK_MHZ = 125;
   localparam int unsigned CAL_TIME_US = 400000;
   localparam int unsigned CAL_CYCLES  = CAL_TIME_US * SYS_CLK_MHZ;

   // ==========================================================
   // Byte map
   localparam logic [3:0] ADDR_DATA_HI = 4'h0;
   localparam logic [3:0] ADDR_DATA_MD = 4'h1;
   localparam logic [3:0] ADDR_DATA_LO = 4'h2;
   localparam logic [3:0] ADDR_CFG_HI  = 4'h4;
   localparam logic [3:0] ADDR_CFG_LO  = 4'h5;
   localparam logic [3:0] ADDR_OFF_HI  = 4'h8;
   localparam logic [3:0] ADDR_OFF_MD  = 4'h9;
   localparam logic [3:0] ADDR_OFF_LO  = 4'hA;
   localparam logic [3:0] ADDR_GAIN_HI = 4'hC;
   localparam logic [3:0] ADDR_GAIN_MD = 4'hD;
   localparam logic [3:0] ADDR_GAIN_LO = 4'hE;
   localparam int         MAP_BYTES    = 16;

   // ==========================================================
   // Configuration word fields
   localparam int CFG_ADAPT     = 15;
   localparam int CFG_CAL_CONN  = 14;
   localparam int CFG_TRIM_CLR  = 9;
   localparam int CFG_RES20     = 7;
   localparam int CFG_CODE_CLR  = 6;
   localparam int CFG_STRAIGHT  = 5;
   localparam int CFG_BOOST_OFF = 4;
   localparam int CFG_BYTE_DEC  = 3;
   localparam int CFG_LSB_FIRST = 2;
   localparam int CFG_MODE_HI   = 1;
   localparam int CFG_MODE_LO   = 0;

   localparam logic [15:0] CFG_RESET   = 16'h2002;
   localparam logic [15:0] CFG_WR_MASK = 16'hC2FF;
   localparam logic [15:0] CFG_RO_ONES = 16'h2000;

   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_CAL    = 2'h1;

   // ==========================================================
   // Reset and clear values
   localparam logic [23:0] DATA_RESET = 24'h000000;
   localparam logic [23:0] OFF_RESET  = 24'h000000;
   localparam logic [23:0] GAIN_RESET = 24'h800000;
   localparam logic [19:0] TC_MIDSCALE = 20'h80000;

   // ==========================================================
   // Command byte fields
   localparam int         CMD_READ    = 7;
   localparam int         CMD_CNT_HI  = 6;
   localparam int         CMD_CNT_LO  = 5;
   localparam logic [1:0] CNT_BAD     = 2'h3;
   localparam logic [1:0] CNT_MAX     = 2'h2;
   localparam logic [2:0] BIT_LAST    = 3'h7;

   typedef enum {ST_CMD, ST_DATA} dmc_link_st_t;

endpackage : dmc_pkg

// [hw/dmc_top.sv]
`timescale 1ns/1ps
module dmc_top
   import dmc_pkg::*;
#(
   parameter int unsigned CAL_CYCLES_P = CAL_CYCLES
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        LINK_SCLK,
   input  wire logic        LINK_CS_N,
   input  wire logic        LINK_SDIO_I,
   output logic             LINK_SDIO_O,
   output logic             LINK_SDIO_OE,
   input  wire logic        STEP_LARGE,
   output logic [19:0]      DAC_LEVEL,
   output logic             DAC_OUT_EN,
   output logic             FILTER_FAST,
   output logic             CAL_ACTIVE,
   output logic [23:0]      OFFSET_TRIM,
   output logic [23:0]      GAIN_TRIM
);

   // ==========================================================
   // Helpers
   function automatic logic bit_of(input logic [7:0] b, input logic [2:0] i,
                                   input logic lsb);
      return lsb ? b[i] : b[BIT_LAST - i];
   endfunction : bit_of

   function automatic logic [7:0] map_byte(input logic [3:0]  a,
                                           input logic [23:0] data,
                                           input logic [15:0] cfg,
                                           input logic [23:0] off,
                                           input logic [23:0] gain);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         ADDR_DATA_HI: r = data[23:16];
         ADDR_DATA_MD: r = data[15:8];
         ADDR_DATA_LO: r = data[7:0];
         ADDR_CFG_HI:  r = cfg[15:8];
         ADDR_CFG_LO:  r = cfg[7:0];
         ADDR_OFF_HI:  r = off[23:16];
         ADDR_OFF_MD:  r = off[15:8];
         ADDR_OFF_LO:  r = off[7:0];
         ADDR_GAIN_HI: r = gain[23:16];
         ADDR_GAIN_MD: r = gain[15:8];
         ADDR_GAIN_LO: r = gain[7:0];
         default:      r = 8'h00;
      endcase
      return r;
   endfunction : map_byte

   // ==========================================================
   // Declarations
   dmc_link_st_t st_q;
   logic [7:0]   shift_q;
   logic [2:0]   bit_q;
   logic [1:0]   byte_q;
   logic [7:0]   cmd_q;
   logic [3:0]   addr_q;
   logic [7:0]   wbuf_q [3];
   logic [3:0]   wadr_q [3];
   logic [1:0]   wcnt_q;
   logic         commit_tgl_q;
   logic         sdo_q;
   logic         sdo_oe_q;

   logic [7:0]   snap_q [MAP_BYTES];
   logic         snap_refresh_q;
   logic         cs_s1_q;
   logic         cs_s2_q;
   logic         tgl_s1_q;
   logic         tgl_s2_q;
   logic         tgl_s3_q;
   logic         step_s1_q;
   logic         step_s2_q;
   logic [23:0]  data_q;
   logic [23:0]  data_d;
   logic [15:0]  cfg_q;
   logic [15:0]  cfg_d;
   logic [23:0]  off_q;
   logic [23:0]  off_d;
   logic [23:0]  gain_q;
   logic [23:0]  gain_d;
   logic [31:0]  cal_cnt_q;
   logic [19:0]  level_q;
   logic         out_en_q;
   logic         fast_q;
   logic         cal_act_q;

   logic [7:0]   in_byte;
   logic         byte_done;
   logic [1:0]   cnt;
   logic         last_byte;
   logic         lsb_first;
   logic         dec;
   logic [3:0]   next_addr;
   logic         commit;
   logic         cal_done;
   logic [1:0]   mode;
   logic [19:0]  code;

   // ==========================================================
   // Link side: frame decode on falling SCLK, reset by RST or idle select
   assign lsb_first = snap_q[ADDR_CFG_LO][CFG_LSB_FIRST];
   assign in_byte   = (st_q == ST_CMD || !lsb_first) ? {shift_q[6:0], LINK_SDIO_I}
                                                     : {LINK_SDIO_I, shift_q[7:1]};
   assign byte_done = (bit_q == BIT_LAST);
   assign cnt       = (cmd_q[CMD_CNT_HI:CMD_CNT_LO] == CNT_BAD) ? CNT_MAX
                                                                : cmd_q[CMD_CNT_HI:CMD_CNT_LO];
   assign last_byte = (byte_q == cnt);
   // Writes that start at a configuration byte always step upward
   assign dec       = snap_q[ADDR_CFG_LO][CFG_BYTE_DEC]
                      && !(!cmd_q[CMD_READ] && cmd_q[3:1] == ADDR_CFG_HI[3:1]);
   assign next_addr = dec ? addr_q - 4'h1 : addr_q + 4'h1;

   always_ff @(negedge LINK_SCLK or posedge RST or posedge LINK_CS_N) begin
      if (RST || LINK_CS_N) begin
         st_q    <= ST_CMD;
         shift_q <= 8'h00;
         bit_q   <= 3'h0;
         byte_q  <= 2'h0;
         cmd_q   <= 8'h00;
         addr_q  <= 4'h0;
      end else begin
         shift_q <= in_byte;
         bit_q   <= bit_q + 3'h1;
         case (st_q)
            ST_CMD: begin
               if (byte_done) begin
                  cmd_q  <= in_byte;
                  addr_q <= in_byte[3:0];
                  byte_q <= 2'h0;
                  st_q   <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (byte_done) begin
                  addr_q <= next_addr;
                  byte_q <= byte_q + 2'h1;
                  if (last_byte) begin
                     st_q <= ST_CMD;
                  end
               end
            end
            default: st_q <= ST_CMD;
         endcase
      end
   end

   // Write bytes are gathered and handed over once, at the last bit
   always_ff @(negedge LINK_SCLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < 3; i++) begin
            wbuf_q[i] <= 8'h00;
            wadr_q[i] <= 4'h0;
         end
         wcnt_q       <= 2'h0;
         commit_tgl_q <= 1'b0;
      end else if (!LINK_CS_N && st_q == ST_DATA && byte_done && !cmd_q[CMD_READ]) begin
         wbuf_q[byte_q] <= in_byte;
         wadr_q[byte_q] <= addr_q;
         if (last_byte) begin
            wcnt_q       <= byte_q;
            commit_tgl_q <= ~commit_tgl_q;
         end
      end
   end

   // Read data driven on falling edge, sampled by host on rising edge
   always_ff @(negedge LINK_SCLK or posedge RST or posedge LINK_CS_N) begin
      if (RST || LINK_CS_N) begin
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (st_q == ST_CMD) begin
         if (byte_done && in_byte[CMD_READ]) begin
            sdo_oe_q <= 1'b1;
            sdo_q    <= bit_of(snap_q[in_byte[3:0]], 3'h0, lsb_first);
         end
      end else if (cmd_q[CMD_READ]) begin
         if (byte_done && last_byte) begin
            sdo_oe_q <= 1'b0;
         end else if (byte_done) begin
            sdo_q <= bit_of(snap_q[next_addr], 3'h0, lsb_first);
         end else begin
            sdo_q <= bit_of(snap_q[addr_q], bit_q + 3'h1, lsb_first);
         end
      end
   end

   assign LINK_SDIO_O  = sdo_q;
   assign LINK_SDIO_OE = sdo_oe_q;

   // ==========================================================
   // Crossings into SYS_CLK
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         tgl_s1_q  <= 1'b0;
         tgl_s2_q  <= 1'b0;
         tgl_s3_q  <= 1'b0;
         step_s1_q <= 1'b0;
         step_s2_q <= 1'b0;
      end else begin
         cs_s1_q   <= LINK_CS_N;
         cs_s2_q   <= cs_s1_q;
         tgl_s1_q  <= commit_tgl_q;
         tgl_s2_q  <= tgl_s1_q;
         tgl_s3_q  <= tgl_s2_q;
         step_s1_q <= STEP_LARGE;
         step_s2_q <= step_s1_q;
      end
   end

   assign commit = tgl_s2_q ^ tgl_s3_q;

   // Read image frozen while a frame is open, except right after a commit
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         snap_refresh_q <= 1'b0;
         for (int i = 0; i < MAP_BYTES; i++) begin
            snap_q[i] <= 8'h00;
         end
      end else begin
         snap_refresh_q <= commit;
         if (cs_s2_q || snap_refresh_q) begin
            for (int i = 0; i < MAP_BYTES; i++) begin
               snap_q[i] <= map_byte(4'(i), data_q, cfg_q, off_q, gain_q);
            end
         end
      end
   end

   // ==========================================================
   // Register map update
   assign mode     = cfg_q[CFG_MODE_HI:CFG_MODE_LO];
   assign cal_done = (mode == MODE_CAL) && (cal_cnt_q == CAL_CYCLES_P - 1);

   always_comb begin
      data_d = data_q;
      cfg_d  = cfg_q;
      off_d  = off_q;
      gain_d = gain_q;
      if (cal_done) begin
         cfg_d[CFG_MODE_HI:CFG_MODE_LO] = MODE_NORMAL;
      end
      if (commit) begin
         for (int i = 0; i < 3; i++) begin
            if (2'(i) <= wcnt_q) begin
               case (wadr_q[i])
                  ADDR_DATA_HI: data_d[23:16] = wbuf_q[i];
                  ADDR_DATA_MD: data_d[15:8]  = wbuf_q[i];
                  ADDR_DATA_LO: data_d[7:0]   = wbuf_q[i];
                  ADDR_CFG_HI:  cfg_d[15:8]   = wbuf_q[i];
                  ADDR_CFG_LO:  cfg_d[7:0]    = wbuf_q[i];
                  ADDR_OFF_HI:  off_d[23:16]  = wbuf_q[i];
                  ADDR_OFF_MD:  off_d[15:8]   = wbuf_q[i];
                  ADDR_OFF_LO:  off_d[7:0]    = wbuf_q[i];
                  ADDR_GAIN_HI: gain_d[23:16] = wbuf_q[i];
                  ADDR_GAIN_MD: gain_d[15:8]  = wbuf_q[i];
                  ADDR_GAIN_LO: gain_d[7:0]   = wbuf_q[i];
                  default: ;
               endcase
            end
         end
         cfg_d = (cfg_d & CFG_WR_MASK) | CFG_RO_ONES;
         // Clear strobes act and self-clear only in normal mode
         if (cfg_d[CFG_MODE_HI:CFG_MODE_LO] == MODE_NORMAL) begin
            if (cfg_d[CFG_TRIM_CLR]) begin
               off_d  = OFF_RESET;
               gain_d = GAIN_RESET;
            end
            if (cfg_d[CFG_CODE_CLR]) begin
               data_d = DATA_RESET;
            end
            cfg_d[CFG_TRIM_CLR] = 1'b0;
            cfg_d[CFG_CODE_CLR] = 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         data_q <= DATA_RESET;
         cfg_q  <= CFG_RESET;
         off_q  <= OFF_RESET;
         gain_q <= GAIN_RESET;
      end else begin
         data_q <= data_d;
         cfg_q  <= cfg_d;
         off_q  <= off_d;
         gain_q <= gain_d;
      end
   end

   // Calibration timer
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cal_cnt_q <= 32'h00000000;
      end else if (mode != MODE_CAL || cal_done) begin
         cal_cnt_q <= 32'h00000000;
      end else begin
         cal_cnt_q <= cal_cnt_q + 32'h00000001;
      end
   end

   // ==========================================================
   // Converter-facing outputs
   assign code = cfg_q[CFG_RES20] ? data_q[23:4] : {data_q[23:8], 4'h0};

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         level_q   <= 20'h00000;
         out_en_q  <= 1'b0;
         fast_q    <= 1'b0;
         cal_act_q <= 1'b0;
      end else begin
         // Two's complement form (CFG_STRAIGHT clear) shifts by half scale of the active resolution
         level_q   <= cfg_q[CFG_STRAIGHT] ? code : code ^ TC_MIDSCALE;
         out_en_q  <= (mode == MODE_NORMAL)
                      || (mode == MODE_CAL && cfg_q[CFG_CAL_CONN]);
         fast_q    <= !cfg_q[CFG_BOOST_OFF]
                      && (cfg_q[CFG_ADAPT] || step_s2_q);
         cal_act_q <= (mode == MODE_CAL);
      end
   end

   assign DAC_LEVEL   = level_q;
   assign DAC_OUT_EN  = out_en_q;
   assign FILTER_FAST = fast_q;
   assign CAL_ACTIVE  = cal_act_q;
   assign OFFSET_TRIM = off_q;
   assign GAIN_TRIM   = gain_q;

endmodule : dmc_top

// [tb/dmc_top_checker.sv]
`timescale 1ns/1ps
// ====
// Port checker
module dmc_top_checker
   import dmc_pkg::*;
#(
   parameter int unsigned CAL_CYCLES_P = 20
) (
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        LINK_SCLK,
   input wire logic        LINK_CS_N,
   input wire logic        LINK_SDIO_I,
   input wire logic        LINK_SDIO_O,
   input wire logic        LINK_SDIO_OE,
   input wire logic        STEP_LARGE,
   input wire logic [19:0] DAC_LEVEL,
   input wire logic        DAC_OUT_EN,
   input wire logic        FILTER_FAST,
   input wire logic        CAL_ACTIVE,
   input wire logic [23:0] OFFSET_TRIM,
   input wire logic [23:0] GAIN_TRIM
);
   logic [31:0] cal_cnt_q;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cal_cnt_q <= '0;
      end else if (CAL_ACTIVE) begin
         cal_cnt_q <= cal_cnt_q + 32'h1;
      end else begin
         cal_cnt_q <= '0;
      end
   end
   a_oe_selected: assert property (LINK_SDIO_OE |-> !LINK_CS_N)
      else $error("SDIO driven while deselected");
   a_reset_state: assert property ($fell(RST) |-> GAIN_TRIM == 24'h800000 && !DAC_OUT_EN)
      else $error("bad state at reset release");
   a_reset_level: assert property ($fell(RST) |=> DAC_LEVEL == 20'h80000)
      else $error("level not midscale after reset");
   a_cal_bound: assert property (cal_cnt_q <= CAL_CYCLES_P + 2)
      else $error("calibration too long");
   a_cal_min: assert property ($fell(CAL_ACTIVE) |-> $past(cal_cnt_q) + 2 >= CAL_CYCLES_P)
      else $error("calibration too short");
   a_cal_reconnect: assert property ($fell(CAL_ACTIVE) |-> ##[0:2] DAC_OUT_EN)
      else $error("output not reconnected");
   a_trims_hold: assert property (LINK_CS_N [*6] ##0 (CAL_ACTIVE && $past(CAL_ACTIVE))
      |-> $stable(OFFSET_TRIM) && $stable(GAIN_TRIM))
      else $error("trims moved during calibration");
   a_output_quiet: assert property (LINK_CS_N [*6] ##0 (!CAL_ACTIVE && !$past(CAL_ACTIVE, 2))
      |-> $stable(DAC_LEVEL) && $stable(DAC_OUT_EN))
      else $error("output moved without a write");
   a_filter_step: assert property (LINK_CS_N [*6] ##0 $changed(FILTER_FAST)
      |-> FILTER_FAST == $past(STEP_LARGE, 3))
      else $error("filter moved without step");
endmodule : dmc_top_checker

bind dmc_top dmc_top_checker #(.CAL_CYCLES_P(CAL_CYCLES_P)) i_dmc_top_checker (
   .SYS_CLK(SYS_CLK), .RST(RST), .LINK_SCLK(LINK_SCLK), .LINK_CS_N(LINK_CS_N),
   .LINK_SDIO_I(LINK_SDIO_I), .LINK_SDIO_O(LINK_SDIO_O), .LINK_SDIO_OE(LINK_SDIO_OE),
   .STEP_LARGE(STEP_LARGE), .DAC_LEVEL(DAC_LEVEL), .DAC_OUT_EN(DAC_OUT_EN),
   .FILTER_FAST(FILTER_FAST), .CAL_ACTIVE(CAL_ACTIVE), .OFFSET_TRIM(OFFSET_TRIM),
   .GAIN_TRIM(GAIN_TRIM));

// [tb/dmc_host_model.sv]
`timescale 1ns/1ps
// ====
// Serial host
module dmc_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_i,
   input wire logic  sdio_o,
   input wire logic  sdio_oe
);
   logic drv_bit;
   assign sdio_i = sdio_oe ? sdio_o : drv_bit;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      drv_bit = 1'b0;
   end
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
                       output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd};
      rd = '0;
      cs_n = 1'b0;
      #40;
      // Data moves 1 ns after the falling edge that samples it
      for (int i = 0; i < 8 * (nb + 1); i++) begin
         #1 drv_bit = sh[31 - i];
         #2 sclk = 1'b1;
         if (i >= 8) rd = {rd[22:0], sdio_i};
         #3 sclk = 1'b0;
      end
      // Commit lands while still selected
      #60 cs_n = 1'b1;
      drv_bit = ~drv_bit;
   endtask : xfer
endmodule : dmc_host_model

// [tb/testbench.sv]
`timescale 1ns/1ps
// ====
// Register level tests
module testbench
   import dmc_pkg::*;
;
   logic        SYS_CLK, RST, LINK_SCLK, LINK_CS_N, LINK_SDIO_I, LINK_SDIO_O;
   logic        LINK_SDIO_OE, STEP_LARGE, DAC_OUT_EN, FILTER_FAST, CAL_ACTIVE;
   logic [19:0] DAC_LEVEL;
   logic [23:0] OFFSET_TRIM, GAIN_TRIM;
   int          n_errors, tests_run;
   logic [15:0] cf [5] = '{16'hA000, 16'h2000, 16'h2000, 16'h2010, 16'hA010};
   logic        st [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   logic        ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [7:0]  lb [4] = '{8'h00, 8'h20, 8'h80, 8'hA0};
   logic [23:0] dw [4] = '{24'h7FFF12, 24'h8000AB, 24'h00001F, 24'hFFFFF7};
   logic [19:0] lv [4] = '{20'hFFFF0, 20'h80000, 20'h80001, 20'hFFFFF};

   always #4 SYS_CLK = ~SYS_CLK;

   dmc_top #(.CAL_CYCLES_P(20)) i_dmc_top (
      .SYS_CLK(SYS_CLK), .RST(RST), .LINK_SCLK(LINK_SCLK), .LINK_CS_N(LINK_CS_N),
      .LINK_SDIO_I(LINK_SDIO_I), .LINK_SDIO_O(LINK_SDIO_O), .LINK_SDIO_OE(LINK_SDIO_OE),
      .STEP_LARGE(STEP_LARGE), .DAC_LEVEL(DAC_LEVEL), .DAC_OUT_EN(DAC_OUT_EN),
      .FILTER_FAST(FILTER_FAST), .CAL_ACTIVE(CAL_ACTIVE), .OFFSET_TRIM(OFFSET_TRIM),
      .GAIN_TRIM(GAIN_TRIM));
   dmc_host_model i_dmc_host_model (.sclk(LINK_SCLK), .cs_n(LINK_CS_N),
      .sdio_i(LINK_SDIO_I), .sdio_o(LINK_SDIO_O), .sdio_oe(LINK_SDIO_OE));

   task automatic close_out;
      $display("Checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input int n, input logic [23:0] v);
      logic [23:0] r;
      i_dmc_host_model.xfer({1'b0, 2'(n - 1), 1'b0, a}, v << (8 * (3 - n)), n, r);
      repeat (4) @(negedge SYS_CLK);
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input int n, input logic [23:0] e);
      logic [23:0] r;
      i_dmc_host_model.xfer({1'b1, 2'(n - 1), 1'b0, a}, 24'h0, n, r);
      repeat (4) @(negedge SYS_CLK);
      chk(r, e);
   endtask : rdchk
   task automatic wait_cal;
      for (int i = 0; i < 200 && CAL_ACTIVE !== 1'b0; i++) @(negedge SYS_CLK);
      if (CAL_ACTIVE !== 1'b0) begin
         n_errors++;
         close_out();
      end
   endtask : wait_cal

   initial begin
      SYS_CLK = 1'b0;
      RST = 1'b1;
      STEP_LARGE = 1'b0;
      n_errors = 0;
      tests_run = 0;
      repeat (10) @(negedge SYS_CLK);
      RST = 1'b0;
      repeat (2) @(negedge SYS_CLK);
      chk(DAC_LEVEL, 24'h080000);
      chk(DAC_OUT_EN, 24'h0);
      repeat (4) @(negedge SYS_CLK);
      rdchk(4'h4, 2, 24'h002002);
      wr(4'h4, 2, 24'h00FD00);
      rdchk(4'h4, 2, 24'h00E000);
      chk(DAC_OUT_EN, 24'h1);
      for (int i = 0; i < 5; i++) begin
         wr(4'h4, 2, {8'h00, cf[i]});
         STEP_LARGE = st[i];
         repeat (6) @(negedge SYS_CLK);
         chk(FILTER_FAST, ex[i]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(4'h4, 2, {8'h00, 8'h20, lb[i]});
         wr(4'h0, 3, dw[i]);
         chk(DAC_LEVEL, lv[i]);
      end
      wr(4'h3, 1, 24'h0000FF);
      rdchk(4'h2, 3, 24'hF70020);
      wr(4'h8, 3, 24'h123456);
      wr(4'hC, 3, 24'hABCDEF);
      chk(OFFSET_TRIM, 24'h123456);
      chk(GAIN_TRIM, 24'hABCDEF);
      rdchk(4'h8, 3, 24'h123456);
      wr(4'h4, 2, 24'h002001);
      chk(CAL_ACTIVE, 24'h1);
      chk(DAC_OUT_EN, 24'h0);
      wait_cal();
      rdchk(4'h4, 2, 24'h002000);
      chk(DAC_OUT_EN, 24'h1);
      wr(4'h4, 2, 24'h006001);
      chk(DAC_OUT_EN, 24'h1);
      wait_cal();
      rdchk(4'h4, 2, 24'h006000);
      chk(GAIN_TRIM, 24'hABCDEF);
      // Byte decrement and LSB-first data bits
      wr(4'h4, 2, 24'h00200C);
      wr(4'h2, 3, 24'h01030F);
      chk(DAC_LEVEL, 24'h070C00);
      rdchk(4'h2, 3, 24'h01030F);
      // Config bytes arrive bit-reversed here, so 20h lands as 04h
      wr(4'h4, 2, 24'h002000);
      // Trim clear and code clear in normal mode
      wr(4'h4, 2, 24'h002240);
      chk(OFFSET_TRIM, 24'h000000);
      chk(GAIN_TRIM, 24'h800000);
      chk(DAC_LEVEL, 24'h080000);
      rdchk(4'h4, 2, 24'h002000);
      close_out();
   end
endmodule : testbench
